// ---- parameter_telegram_interpreter_tb_top.sv ----
// testbench: telegram runs through the registers against the model
`timescale 1ns/1ps
module parameter_telegram_interpreter_tb_top;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0, r, k, rdv, ep = 32'h0400_1234;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, txValid, txReady, rxValid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] txWord, rxWord;
    logic [32:0] e, rQ[$];
    logic [1:0] bQ[$];
    int mismatches = 0, n_compared = 0, cyc = 0;
    parameter_telegram_master dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .txWord(txWord), .txValid(txValid),
        .txReady(txReady), .rxWord(rxWord), .rxValid(rxValid),
        .telegramLengthByte());
    tg_device dev (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
        .txWord(txWord), .txValid(txValid), .txReady(txReady),
        .rxWord(rxWord), .rxValid(rxValid));
    always #20 sys_clk = ~sys_clk;
    ////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] s, x);
        n_compared++;
        if (s !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // bus answers are compared against the oldest note
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rvalid && rready) begin
            e = rQ.pop_front();
            if (e[32]) check("rdata", rdata, e[31:0]);
            check("rresp", {30'h0, rresp}, 32'h0);
        end
        if (bvalid && bready) check("bresp", {30'h0, bresp}, {30'h0, bQ[0]});
        if (bvalid && bready) bQ.pop_front();
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] x);
        bQ.push_back(x);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] x, input int c);
        rQ.push_back({c[0], x});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdv = rdata;
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    // one telegram: load, start, wait for done, compare the reply
    task automatic run(input logic [31:0] ky, x, v, p, g, ek, ex, ev, es);
        slow <= 1'($urandom_range(1));
        wr(6'h08, ky, 2'b00);
        wr(6'h0c, x, 2'b00);
        wr(6'h10, v, 2'b00);
        wr(6'h14, p, 2'b00);
        wr(6'h00, 32'h2, 2'b00);
        wr(6'h00, g, 2'b00);
        rdv = 32'h0;
        for (int i = 0; i < 300 && rdv[1] !== 1'b1; i++) rd(6'h04, 0, 0);
        rd(6'h04, es, 1);
        rd(6'h18, ek, 1);
        rd(6'h1c, ex, 1);
        rd(6'h20, ev, 1);
        rd(6'h24, ep, 1);
    endtask
    initial begin
        void'($urandom(45));
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(6'h04, 0, 1);
        rd(6'h24, 0, 1);
        rd(6'h28, 0, 1);
        wr(6'h28, 32'h1, 2'b10);
        r = $urandom;
        k = (r[31:16] != 16'h0) ? 32'h2005 : 32'h1005;
        run(32'h3005, 0, r, ep, 1, 32'h2005, 0, r, 2);
        run(32'h1005, 0, ~r, 32'h5555, 1, k, 0, r, 2);
        run(32'he003, 0, 32'h14, 0, 1, 32'h1003, 0, 32'h14, 2);
        run(32'hd003, 0, 32'h1_0064, 0, 1, 32'h2003, 0, 32'h1_0064, 2);
        run(32'h1267, 32'h0107, 0, 0, 1, 32'h1267, 32'h0107, 8, 2);
        run(32'h17ff, 0, 0, 0, 1, 32'h77ff, 0, 0, 6);
        run(32'hf26d, 0, 0, 0, 1, 32'hf26d, 32'h0400, 0, 2);
        run(32'hf215, 0, 0, 0, 4, 32'hf215, 32'h0500, 0, 2);
        run(32'hf26d, 0, 0, 0, 4, 32'h726d, 32'h0500, 1, 6);
        run(32'h0005, 0, 0, 0, 1, 32'h0005, 0, 0, 2);
        run(32'h2009, 0, r, 0, 1, 32'h1009, 0, r, 2);
        run(32'h1009, 0, 0, 0, 1, 32'h1009, 0, {16'h0, r[15:0]}, 2);
        end_sim();
    end
endmodule

// ---- parameter_telegram_master.sv ----
// host controller: builds request telegrams, collects replies, axi-lite regs
`timescale 1ns/1ps
module parameter_telegram_master (
    input wire logic sys_clk,
    input wire logic rst_b,
    // axi4-lite slave
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // word link toward the telegram framer
    output logic [15:0] txWord,
    output logic txValid,
    input wire logic txReady,
    input wire logic [15:0] rxWord,
    input wire logic rxValid,
    output logic [7:0] telegramLengthByte
);
    typedef enum {IDLE, SEND, WAIT_REPLY} phase_type;
    typedef struct packed {
        phase_type phase;
        logic [2:0] cnt;
        // bus slave state
        logic awDone;
        logic wDone;
        logic [5:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // request registers and the collected reply
        logic [15:0] key;
        logic [15:0] index;
        logic [31:0] value;
        logic [31:0] process;
        logic [95:0] reply;
        // status flags and link outputs
        logic done;
        logic fail;
        logic badIndex;
        logic [15:0] txWord;
        logic txValid;
        logic [7:0] lenByte;
        logic awReady;
        logic wReady;
        logic arReady;
    } state_type;
    state_type st;
    state_type next_st;

    logic load;
    logic shift;
    logic [95:0] request;
    logic [95:0] held;
    logic [15:0] outWord;
    logic [31:0] rd;
    logic [3:0] code;
    logic go;

    // request words in transmit order
    logic [15:0] keyWord;
    logic [15:0] indexWord;
    logic [15:0] valueHigh;
    logic [15:0] valueLow;
    logic [15:0] controlWord;
    logic [15:0] referenceWord;

    // register write merge and control commands
    logic [31:0] oldWord;
    logic [31:0] newWord;
    logic startPlain;
    logic startText;
    logic clearFlags;

    // reply decode
    logic [3:0] replyCode;
    logic [31:0] replyValue;
    logic replyFailed;
    logic codeOutOfRange;
    logic [31:0] statusWord;

    // channel handshakes
    logic awTake;
    logic wTake;
    logic bDone;
    logic arTake;
    logic rDone;
    logic txTake;

    ////////////////////////////////////////////////////////////////////////
    // request telegram: key, index, value high, low, control, reference
    always_comb begin
        code = st.key[telegram_pkg::CODE_LSB +: telegram_pkg::CODE_W];
        keyWord = st.key;
        indexWord = st.index;
        valueHigh = st.value[31:16];
        valueLow = st.value[15:0];
        controlWord = st.process[31:16];
        referenceWord = st.process[15:0];
        // a read request carries an empty value field
        if (code == telegram_pkg::CMD_READ) begin
            valueHigh = 16'h0000;
            valueLow = 16'h0000;
        end
        // text command: the index high byte tells write from read
        if (code == telegram_pkg::CMD_TEXT) begin
            indexWord = startText ? telegram_pkg::IDX_TEXT_WRITE
                : telegram_pkg::IDX_TEXT_READ;
        end
        request = {keyWord, indexWord, valueHigh, valueLow, controlWord,
            referenceWord};
    end

    word_shifter #(.N(telegram_pkg::WORDS)) shifter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .load(load),
        .loadData(request),
        .shift(shift),
        .inWord(rxWord),
        .outWord(outWord),
        .held(held)
    );

    ////////////////////////////////////////////////////////////////////////
    // byte lanes left out of a write keep the register's old contents
    always_comb begin
        case (st.awAddr)
            telegram_pkg::OFF_KEY: oldWord = {16'h0000, st.key};
            telegram_pkg::OFF_INDEX: oldWord = {16'h0000, st.index};
            telegram_pkg::OFF_VALUE: oldWord = st.value;
            telegram_pkg::OFF_PROCESS: oldWord = st.process;
            default: oldWord = 32'h0000_0000;
        endcase
        newWord = oldWord;
        for (int b = 0; b < 4; b++) begin
            if (st.wStrb[b]) begin
                newWord[b*8 +: 8] = st.wData[b*8 +: 8];
            end
        end
        // control register bits act as one-shot commands
        startPlain = newWord[0];
        clearFlags = newWord[1];
        startText = newWord[2];
    end

    ////////////////////////////////////////////////////////////////////////
    // reply fields as they stand once five reply words are shifted in
    always_comb begin
        replyCode = held[79:76];
        replyValue = {held[47:32], held[31:16]};
        replyFailed = replyCode == telegram_pkg::RPL_FAIL;
        // an error-code entry must lie in 1..99
        codeOutOfRange = replyValue == 32'h0000_0000
            || replyValue > 32'd99;
    end

    ////////////////////////////////////////////////////////////////////////
    // handshakes: a channel moves when its valid meets the ready
    always_comb begin
        awTake = s_axi_awvalid && st.awReady;
        wTake = s_axi_wvalid && st.wReady;
        bDone = st.bvalid && s_axi_bready;
        arTake = s_axi_arvalid && st.arReady;
        rDone = st.rvalid && s_axi_rready;
        txTake = st.txValid && txReady;
    end

    ////////////////////////////////////////////////////////////////////////
    // status: busy, done, failed reply, error code out of range
    assign statusWord = {28'h0000000, st.badIndex, st.fail, st.done,
        st.phase != IDLE};

    // register read mux
    always_comb begin
        case (s_axi_araddr)
            telegram_pkg::OFF_CTRL: rd = 32'h0000_0000;
            telegram_pkg::OFF_STATUS: rd = statusWord;
            telegram_pkg::OFF_KEY: rd = {16'h0000, st.key};
            telegram_pkg::OFF_INDEX: rd = {16'h0000, st.index};
            telegram_pkg::OFF_VALUE: rd = st.value;
            telegram_pkg::OFF_PROCESS: rd = st.process;
            telegram_pkg::OFF_RKEY: rd = {16'h0000, st.reply[95:80]};
            telegram_pkg::OFF_RINDEX: rd = {16'h0000, st.reply[79:64]};
            telegram_pkg::OFF_RVALUE: rd = st.reply[63:32];
            telegram_pkg::OFF_RPROCESS: rd = st.reply[31:0];
            default: rd = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: bus slave, register writes, telegram sequencing
    always_comb begin
        next_st = st;
        load = 1'b0;
        shift = 1'b0;
        go = 1'b0;
        // write address and data taken in either order
        if (awTake) begin
            next_st.awDone = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (wTake) begin
            next_st.wDone = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.awDone && st.wDone) begin
            next_st.awDone = 1'b0;
            next_st.wDone = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = telegram_pkg::RESP_OKAY;
            case (st.awAddr)
                telegram_pkg::OFF_CTRL: begin
                    if (clearFlags) begin
                        next_st.done = 1'b0;
                        next_st.fail = 1'b0;
                        next_st.badIndex = 1'b0;
                    end
                    go = startPlain | startText;
                end
                // parameter number bits 0..10, code bits 12..15
                telegram_pkg::OFF_KEY: next_st.key = newWord[15:0];
                // only the low byte is a subindex to the device
                telegram_pkg::OFF_INDEX: next_st.index = newWord[15:0];
                // new value or selection ordinal, already scaled integer
                telegram_pkg::OFF_VALUE: next_st.value = newWord;
                telegram_pkg::OFF_PROCESS: next_st.process = newWord;
                default: next_st.bresp = telegram_pkg::RESP_SLVERR;
            endcase
        end
        if (bDone) begin
            next_st.bvalid = 1'b0;
        end
        // reads
        if (arTake) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd;
            next_st.rresp = telegram_pkg::RESP_OKAY;
        end
        if (rDone) begin
            next_st.rvalid = 1'b0;
        end
        // telegram sequencer
        case (st.phase)
            IDLE: begin
                // ctrl bit2 keeps the key but drives a text write when the key code is f
                if (go) begin
                    load = 1'b1;
                    next_st.cnt = 3'd0;
                    next_st.phase = SEND;
                    next_st.txValid = 1'b1;
                    next_st.txWord = request[95:80];
                    next_st.lenByte = 8'd14;
                end
            end
            // one word per taken handshake, six in all
            SEND: begin
                if (txTake) begin
                    shift = 1'b1;
                    if (st.cnt == 3'(telegram_pkg::WORDS - 1)) begin
                        next_st.txValid = 1'b0;
                        next_st.cnt = 3'd0;
                        next_st.phase = WAIT_REPLY;
                    end else begin
                        next_st.cnt = st.cnt + 3'd1;
                        next_st.txWord = held[79:64];
                    end
                end
            end
            // reply words are taken in every cycle that rxValid is high
            WAIT_REPLY: begin
                if (rxValid) begin
                    shift = 1'b1;
                    if (st.cnt == 3'(telegram_pkg::WORDS - 1)) begin
                        next_st.phase = IDLE;
                        next_st.done = 1'b1;
                        next_st.reply = {held[79:0], rxWord};
                        // 0111 reply: error number sits in the value field
                        if (replyFailed) begin
                            next_st.fail = 1'b1;
                        end
                        // error-code entries must lie in 1..99
                        if (!replyFailed && st.index[7:0] != 8'h00 &&
                            codeOutOfRange) begin
                            next_st.badIndex = 1'b1;
                        end
                    end else begin
                        next_st.cnt = st.cnt + 3'd1;
                    end
                end
            end
            default: next_st.phase = IDLE;
        endcase
        // ready flags are registered copies of the free conditions
        next_st.awReady = !next_st.awDone && !next_st.bvalid;
        next_st.wReady = !next_st.wDone && !next_st.bvalid;
        next_st.arReady = !next_st.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.phase <= IDLE;
            st.process <= telegram_pkg::RESET_PROCESS;
            st.awReady <= 1'b1;
            st.wReady <= 1'b1;
            st.arReady <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // every output straight from a flip-flop
    assign s_axi_awready = st.awReady;
    assign s_axi_wready = st.wReady;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arReady;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign txWord = st.txWord;
    assign txValid = st.txValid;
    assign telegramLengthByte = st.lenByte;
endmodule

// ---- telegram_pkg.sv ----
// package: telegram field layouts, command codes and register map
package telegram_pkg;
    localparam int PNU_LSB = 0;
    localparam int PNU_W = 11;
    localparam int CODE_LSB = 12;
    localparam int CODE_W = 4;
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h1;
    localparam logic [3:0] CMD_WR_WORD = 4'h2;
    localparam logic [3:0] CMD_WR_DWORD = 4'h3;
    localparam logic [3:0] CMD_WR_EE_DWORD = 4'hd;
    localparam logic [3:0] CMD_WR_EE_WORD = 4'he;
    localparam logic [3:0] CMD_TEXT = 4'hf;
    localparam logic [3:0] RPL_NONE = 4'h0;
    localparam logic [3:0] RPL_WORD = 4'h1;
    localparam logic [3:0] RPL_DWORD = 4'h2;
    localparam logic [3:0] RPL_FAIL = 4'h7;
    localparam logic [3:0] RPL_TEXT = 4'hf;
    localparam logic [15:0] IDX_TEXT_READ = 16'h0400;
    localparam logic [15:0] IDX_TEXT_WRITE = 16'h0500;
    localparam logic [15:0] CTRL_VALID_MASK = 16'h0400;
    localparam int CTRL_VALID_BIT = 10;
    localparam int WORDS = 6;
    // register byte offsets
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_STATUS = 6'h04;
    localparam logic [5:0] OFF_KEY = 6'h08;
    localparam logic [5:0] OFF_INDEX = 6'h0c;
    localparam logic [5:0] OFF_VALUE = 6'h10;
    localparam logic [5:0] OFF_PROCESS = 6'h14;
    localparam logic [5:0] OFF_RKEY = 6'h18;
    localparam logic [5:0] OFF_RINDEX = 6'h1c;
    localparam logic [5:0] OFF_RVALUE = 6'h20;
    localparam logic [5:0] OFF_RPROCESS = 6'h24;
    localparam logic [31:0] RESET_PROCESS = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- tg_checker.sv ----
// checker: bus and word-link timing of the telegram master
`timescale 1ns/1ps
module tg_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rready,
    input wire logic [15:0] txWord,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [7:0] telegramLengthByte
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] cnt;
    logic [3:0] code;
    ////////////////////////////////////////
    // word position and key code of the outgoing telegram
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 3'h0;
            code <= 4'h0;
        end else if (txValid && txReady) begin
            cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
            if (cnt == 3'h0) code <= txWord[15:12];
        end
    end
    sequence s_arTaken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_last; txValid && txReady && cnt == 3'h5; endsequence
    property p_bHold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rLat; s_arTaken |=> s_axi_rvalid; endproperty
    property p_rHold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_txHold; txValid && !txReady |=> txValid && $stable(txWord);
    endproperty
    property p_code;
        txValid && cnt == 3'h0
            |-> txWord[15:12] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf};
    endproperty
    property p_textIdx;
        txValid && cnt == 3'h1 && code == 4'hf
            |-> txWord inside {16'h0400, 16'h0500};
    endproperty
    property p_readZero;
        txValid && code == 4'h1 && cnt inside {3'h2, 3'h3} |-> txWord == 16'h0;
    endproperty
    property p_len; txValid && txReady |=> telegramLengthByte == 8'h0e;
    endproperty
    property p_six; s_last |=> !txValid [*2]; endproperty
    a_bHold: assert property (p_bHold) else $error("write answer dropped");
    a_rLat: assert property (p_rLat) else $error("read answer late");
    a_rHold: assert property (p_rHold) else $error("read answer dropped");
    a_txHold: assert property (p_txHold) else $error("tx word moved");
    a_code: assert property (p_code) else $error("bad command code");
    a_textIdx: assert property (p_textIdx) else $error("text index");
    a_readZero: assert property (p_readZero) else $error("read value");
    a_len: assert property (p_len) else $error("length byte wrong");
    a_six: assert property (p_six) else $error("extra tx word");
endmodule

bind parameter_telegram_master tg_checker chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rready(s_axi_rready), .txWord(txWord), .txValid(txValid),
    .txReady(txReady), .telegramLengthByte(telegramLengthByte)
);

// ---- tg_device.sv ----
// device model: takes six words, decodes, answers six words
`timescale 1ns/1ps
module tg_device (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic [15:0] txWord,
    input wire logic txValid,
    output logic txReady,
    output logic [15:0] rxWord,
    output logic rxValid
);
    logic [15:0] req [6];
    logic [15:0] rep [6];
    logic [31:0] mem [16];
    logic [31:0] v;
    logic [10:0] parameter_number;
    logic [3:0] rc;
    logic [2:0] n;
    logic ans, dec, bad;
    ////////////////////////////////////////
    // rep[4], rep[5] keep the last accepted control word and reference
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            n <= 3'h0;
            ans <= 1'b0;
            dec <= 1'b0;
            txReady <= 1'b0;
            rxValid <= 1'b0;
            rxWord <= 16'h5a5a;
            rep[4] = 16'h0;
            rep[5] = 16'h0;
        end else if (!ans) begin
            rxValid <= 1'b0;
            rxWord <= ~rxWord; // released line does not hold
            // the sixth word closes intake until the reply is out
            txReady <= !(slow && $urandom_range(1) == 0)
                && !(txValid && txReady && n == 3'h5);
            if (txValid && txReady) begin
                req[n] <= txWord;
                n <= (n == 3'h5) ? 3'h0 : n + 3'h1;
                ans <= (n == 3'h5);
            end
        end else if (!dec) begin
            dec <= 1'b1;
            parameter_number = req[0][10:0];
            rc = req[0][15:12];
            v = {req[2], req[3]};
            bad = rc inside {[4'h4:4'hc]} || (parameter_number > 11'd15 && parameter_number != 11'd615
                && rc != 4'hf && rc != 4'h0);
            if (req[4][10]) begin
                rep[4] = req[4];
                rep[5] = req[5];
            end
            if (bad) begin
                rc = 4'h7;
                v = 32'h0;
            end else case (rc)
                4'h1: begin
                    v = parameter_number == 11'd615 ? 32'(req[1][7:0] % 99 + 1)
                        : mem[parameter_number[3:0]];
                    rc = (v[31:16] == 16'h0) ? 4'h1 : 4'h2;
                end
                4'h2, 4'he: begin
                    mem[parameter_number[3:0]] = {16'h0, v[15:0]};
                    rc = 4'h1;
                end
                4'h3, 4'hd: begin
                    mem[parameter_number[3:0]] = v;
                    rc = 4'h2;
                end
                4'hf: if (req[1][15:8] == 8'h05 && parameter_number != 11'd533
                    && parameter_number != 11'd534) begin
                    rc = 4'h7;
                    v = 32'h1;
                end
                default: ;
            endcase
            rep[0] = {rc, req[0][11:0]};
            rep[1] = req[1];
            rep[2] = v[31:16];
            rep[3] = v[15:0];
        end else if (!(slow && $urandom_range(1) == 0)) begin
            rxWord <= rep[n];
            rxValid <= 1'b1;
            n <= (n == 3'h5) ? 3'h0 : n + 3'h1;
            ans <= (n != 3'h5);
            dec <= (n != 3'h5);
        end else begin
            rxValid <= 1'b0;
            rxWord <= ~rxWord;
        end
    end
endmodule

// ---- word_shifter.sv ----
// word-serial shifter: loads a six-word telegram, shifts it out and in
`timescale 1ns/1ps
module word_shifter #(
    parameter int N = 6
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [N*16-1:0] loadData,
    input wire logic shift,
    input wire logic [15:0] inWord,
    output logic [15:0] outWord,
    output logic [N*16-1:0] held
);
    typedef struct packed {
        logic [N*16-1:0] data;
    } state_type;
    state_type st;
    state_type next_st;

    // load wins, shift moves a word toward the top and takes one in
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.data = loadData;
        end else if (shift) begin
            next_st.data = {st.data[N*16-17:0], inWord};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign outWord = st.data[N*16-1 -: 16];
    assign held = st.data;
endmodule
